// *** design/amos_top.sv ***
// analog monitor output scaler: settings registers, source select and two scaled channels
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "amos_consts.svh"

module amos_top import amos_pkg::*; #(
  parameter int SRC_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic sample_valid_i,
  input wire logic signed [SRC_W-1:0] speed_i,
  input wire logic signed [SRC_W-1:0] torque_i,
  input wire logic signed [SRC_W-1:0] pulse_freq_i,
  input wire logic signed [SRC_W-1:0] speed_cmd_i,
  input wire logic signed [SRC_W-1:0] torque_cmd_i,
  input wire logic signed [SRC_W-1:0] bus_volt_i,
  output logic [15:0] rd_data_o,
  output logic [9:0] channel_one_proportion_code_o,
  output logic [9:0] channel_two_proportion_code_o,
  output logic code_valid_o,
  output logic pulse_dir_rev_o
);

  // the scale arithmetic is sized for samples of 8 to 24 bits
  if (SRC_W < 8 || SRC_W > 24) begin : g_bad_width
    $error("amos_top: SRC_W must lie between 8 and 24");
  end

  // picks one digit of a settings word; used for sources and polarity
  function automatic logic [3:0] digit_of(input logic [15:0] word, input int idx);
    logic [15:0] sh;
    sh = word >> (idx * `AMOS_DIGIT_W);
    return sh[3:0];
  endfunction : digit_of

  // maps a source code to its sample
  function automatic logic signed [SRC_W-1:0] pick_source(input logic [3:0] code,
      input logic signed [SRC_W-1:0] s0, input logic signed [SRC_W-1:0] s1,
      input logic signed [SRC_W-1:0] s2, input logic signed [SRC_W-1:0] s3,
      input logic signed [SRC_W-1:0] s4, input logic signed [SRC_W-1:0] s5);
    logic signed [SRC_W-1:0] res;
    res = '0;
    case (amos_src_t'(code))
      AMOS_SRC_SPEED: res = s0;
      AMOS_SRC_TORQUE: res = s1;
      AMOS_SRC_PULSE_FREQ: res = s2;
      AMOS_SRC_SPEED_CMD: res = s3;
      AMOS_SRC_TORQUE_CMD: res = s4;
      AMOS_SRC_BUS_VOLT: res = s5;
      default: res = '0;
    endcase
    return res;
  endfunction : pick_source

  // true when a word holds legal settings digits
  function automatic logic digits_ok(input logic [15:0] word, input logic [3:0] max0,
      input logic [3:0] max1);
    return (digit_of(word, 0) <= max0) && (digit_of(word, 1) <= max1) && (word[15:8] == 8'h00);
  endfunction : digits_ok

  logic [15:0] src_r, src_nxt;
  logic [15:0] pol_r, pol_nxt;
  logic [15:0] prst_r, prst_nxt;
  logic [15:0] prop_r [2];
  logic [15:0] prop_nxt [2];
  logic signed [15:0] drift_r [2];
  logic signed [15:0] drift_nxt [2];
  logic [15:0] rd_r, rd_nxt;
  logic drift_ok;
  logic [9:0] code_w [2];
  logic code_valid_w [2];

  // out-of-range writes are dropped so the arithmetic never sees bad settings
  assign drift_ok = ($signed(wr_data_i) <= `AMOS_DRIFT_MAX_MV) && ($signed(wr_data_i) >= -`AMOS_DRIFT_MAX_MV);

  // settings register next values
  always_comb begin
    src_nxt = src_r;
    pol_nxt = pol_r;
    prst_nxt = prst_r;
    prop_nxt = prop_r;
    drift_nxt = drift_r;
    if (wr_en_i) begin
      case (addr_i)
        `AMOS_ADDR_SRC: begin
          if (digits_ok(wr_data_i, `AMOS_SRC_MAX, `AMOS_SRC_MAX)) begin
            src_nxt = wr_data_i;
          end
        end
        `AMOS_ADDR_POL: begin
          if (digits_ok(wr_data_i, `AMOS_POL_A_MAX, `AMOS_POL_B_MAX)) begin
            pol_nxt = wr_data_i;
          end
        end
        `AMOS_ADDR_PROP1: begin
          if (wr_data_i <= `AMOS_PROP_MAX) begin
            prop_nxt[0] = wr_data_i;
          end
        end
        `AMOS_ADDR_PROP2: begin
          if (wr_data_i <= `AMOS_PROP_MAX) begin
            prop_nxt[1] = wr_data_i;
          end
        end
        `AMOS_ADDR_DRIFT1: begin
          if (drift_ok) begin
            drift_nxt[0] = wr_data_i;
          end
        end
        `AMOS_ADDR_DRIFT2: begin
          if (drift_ok) begin
            drift_nxt[1] = wr_data_i;
          end
        end
        `AMOS_ADDR_PRST: begin
          prst_nxt = wr_data_i;
          // restore defaults, but the drift offsets are deliberately spared
          if (wr_data_i == `AMOS_PRST_KEEP_DRIFT) begin
            src_nxt = `AMOS_SRC_RST;
            pol_nxt = `AMOS_POL_RST;
            prop_nxt[0] = `AMOS_PROP_RST;
            prop_nxt[1] = `AMOS_PROP_RST;
            drift_nxt = drift_r;
          end
        end
        default: begin
          src_nxt = src_r;
        end
      endcase
    end
  end

  // settings registers; drift resets to zero only on the hard reset
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      src_r <= `AMOS_SRC_RST;
      pol_r <= `AMOS_POL_RST;
      prst_r <= `AMOS_PRST_RST;
      prop_r[0] <= `AMOS_PROP_RST;
      prop_r[1] <= `AMOS_PROP_RST;
      drift_r[0] <= `AMOS_DRIFT_RST;
      drift_r[1] <= `AMOS_DRIFT_RST;
    end else if (ce_i) begin
      src_r <= src_nxt;
      pol_r <= pol_nxt;
      prst_r <= prst_nxt;
      prop_r <= prop_nxt;
      drift_r <= drift_nxt;
    end
  end

  // read data for the cycle after the strobe; unmapped addresses read zero
  always_comb begin
    rd_nxt = 16'h0000;
    if (rd_en_i) begin
      case (addr_i)
        `AMOS_ADDR_SRC: rd_nxt = src_r;
        `AMOS_ADDR_POL: rd_nxt = pol_r;
        `AMOS_ADDR_PROP1: rd_nxt = prop_r[0];
        `AMOS_ADDR_PROP2: rd_nxt = prop_r[1];
        `AMOS_ADDR_DRIFT1: rd_nxt = drift_r[0];
        `AMOS_ADDR_DRIFT2: rd_nxt = drift_r[1];
        `AMOS_ADDR_PRST: rd_nxt = prst_r;
        `AMOS_ADDR_CODE1: rd_nxt = {6'h00, code_w[0]};
        `AMOS_ADDR_CODE2: rd_nxt = {6'h00, code_w[1]};
        default: rd_nxt = 16'h0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rd_r <= 16'h0000;
    end else if (ce_i) begin
      rd_r <= rd_nxt;
    end
  end

  // two identical channels; channel 0 uses source digit 0, channel 1 source digit 1, both polarity digit 0
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic signed [SRC_W-1:0] sample_s;
    logic negate_s;
    amos_mv_t mv_w;
    logic mv_valid_w;
    logic [3:0] pol_a_s;

    assign sample_s = pick_source(digit_of(src_r, c), speed_i, torque_i, pulse_freq_i,
        speed_cmd_i, torque_cmd_i, bus_volt_i);
    // sign 1 flips channel two, 2 flips channel one, 3 flips both
    assign pol_a_s = digit_of(pol_r, 0);
    assign negate_s = (c == 0) ? pol_a_s[1] : pol_a_s[0];

    // pipeline: sign, proportion, offset, then clamp and code
    amos_scale #(
      .SRC_W(SRC_W)
    ) u_scale (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .in_valid_i(sample_valid_i),
      .sample_i(sample_s),
      .negate_i(negate_s),
      .prop_i(prop_r[c][6:0]),
      .drift_i(drift_r[c]),
      .mv_o(mv_w),
      .valid_o(mv_valid_w)
    );

    amos_code u_code (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .in_valid_i(mv_valid_w),
      .mv_i(mv_w),
      .code_o(code_w[c]),
      .valid_o(code_valid_w[c])
    );
  end

  // outputs come straight from the channel and register flops
  assign rd_data_o = rd_r;
  assign channel_one_proportion_code_o = code_w[0];
  assign channel_two_proportion_code_o = code_w[1];
  assign code_valid_o = code_valid_w[0];
  assign pulse_dir_rev_o = pol_r[`AMOS_POL_B_LSB];

endmodule : amos_top

// *** inc/amos_consts.svh ***
// offsets, field positions, reset values and scale figures of the analog monitor scaler
`ifndef AMOS_CONSTS_SVH
`define AMOS_CONSTS_SVH
`define AMOS_ADDR_SRC 16'h0003
`define AMOS_ADDR_POL 16'h0103
`define AMOS_ADDR_PROP1 16'h0104
`define AMOS_ADDR_PROP2 16'h0105
`define AMOS_ADDR_PRST 16'h0208
`define AMOS_ADDR_DRIFT1 16'h0414
`define AMOS_ADDR_DRIFT2 16'h0415
`define AMOS_ADDR_CODE1 16'h0500
`define AMOS_ADDR_CODE2 16'h0501
`define AMOS_SRC_RST 16'h0001
`define AMOS_POL_RST 16'h0000
`define AMOS_PROP_RST 16'h0064
`define AMOS_DRIFT_RST 16'h0000
`define AMOS_PRST_RST 16'h0000
`define AMOS_PRST_KEEP_DRIFT 16'h000A
`define AMOS_DIGIT_W 4
`define AMOS_POL_A_LSB 0
`define AMOS_POL_B_LSB 4
`define AMOS_POL_A_MAX 4'h3
`define AMOS_POL_B_MAX 4'h1
`define AMOS_SRC_MAX 4'h5
`define AMOS_PROP_MAX 16'h0064
`define AMOS_DRIFT_MAX_MV 16'sh0320
`define AMOS_FS_MV 18'sh1F40
`define AMOS_MV_PER_PCT 14'h0050
`define AMOS_SPAN_MV 28'h0000_3E80
`define AMOS_CODE_MAX 28'h0000_03FF
`endif

// *** inc/amos_pkg.sv ***
// types shared by the analog monitor scaler files
package amos_pkg;
  // monitor source codes, in the order of their numeric setting
  typedef enum logic [3:0] {
    AMOS_SRC_SPEED,
    AMOS_SRC_TORQUE,
    AMOS_SRC_PULSE_FREQ,
    AMOS_SRC_SPEED_CMD,
    AMOS_SRC_TORQUE_CMD,
    AMOS_SRC_BUS_VOLT
  } amos_src_t;
  typedef logic signed [17:0] amos_mv_t;
  typedef logic [9:0] amos_code_t;
endpackage : amos_pkg

// *** design/amos_scale.sv ***
// per-channel sign, proportion and drift offset stage
`timescale 1ns/1ps
`include "amos_consts.svh"
module amos_scale import amos_pkg::*; #(
  parameter int SRC_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic signed [SRC_W-1:0] sample_i,
  input wire logic negate_i,
  input wire logic [6:0] prop_i,
  input wire logic signed [15:0] drift_i,
  output amos_mv_t mv_o,
  output logic valid_o
);
  logic signed [SRC_W:0] signed_s;
  logic signed [SRC_W+14:0] prod_s;
  amos_mv_t mv_r, mv_nxt;
  logic valid_r, valid_nxt;

  // one extra bit so negating the most negative sample cannot wrap
  always_comb begin
    signed_s = negate_i ? -SRC_W'(0) - {sample_i[SRC_W-1], sample_i} : {sample_i[SRC_W-1], sample_i};
    prod_s = signed_s * $signed({1'b0, 7'(prop_i) * `AMOS_MV_PER_PCT});
    mv_nxt = mv_r;
    valid_nxt = 1'b0;
    if (in_valid_i) begin
      // full scale of 2^(SRC_W-1) maps to 80 mV per percent
      mv_nxt = amos_mv_t'(prod_s >>> (SRC_W - 1)) + amos_mv_t'(drift_i);
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      mv_r <= '0;
      valid_r <= 1'b0;
    end else if (ce_i) begin
      mv_r <= mv_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign mv_o = mv_r;
  assign valid_o = valid_r;
endmodule : amos_scale

// *** design/amos_code.sv ***
// per-channel saturation and 10-bit converter code stage
`timescale 1ns/1ps
`include "amos_consts.svh"
module amos_code import amos_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input amos_mv_t mv_i,
  output amos_code_t code_o,
  output logic valid_o
);
  amos_mv_t clip_s;
  logic [27:0] lin_s;
  amos_code_t code_r, code_nxt;
  logic valid_r, valid_nxt;

  // clamp first, then map -8 V..+8 V onto 0..1023 offset binary
  always_comb begin
    clip_s = mv_i;
    if (mv_i > `AMOS_FS_MV) clip_s = `AMOS_FS_MV;
    if (mv_i < -`AMOS_FS_MV) clip_s = -`AMOS_FS_MV;
    lin_s = 28'(clip_s + `AMOS_FS_MV) * `AMOS_CODE_MAX / `AMOS_SPAN_MV;
    code_nxt = code_r;
    valid_nxt = 1'b0;
    if (in_valid_i) begin
      code_nxt = lin_s[9:0];
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      code_r <= 10'h200;
      valid_r <= 1'b0;
    end else if (ce_i) begin
      code_r <= code_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign code_o = code_r;
  assign valid_o = valid_r;
endmodule : amos_code

// *** sim/amos_checker_props.sv ***
// property checker for the analog monitor scaler top
`timescale 1ns/1ps
`include "amos_consts.svh"
module amos_checker_props (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] rd_data_o,
  input wire logic [9:0] channel_one_proportion_code_o,
  input wire logic code_valid_o,
  input wire logic pulse_dir_rev_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // sample path answers exactly two running cycles later
  code_lat_a:
    assert property (sample_valid_i && ce_i ##1 ce_i [*2] |-> code_valid_o) else $error("code update late");
  no_stray_a:
    assert property (code_valid_o |-> $past(sample_valid_i, 2)) else $error("code update without sample");
  rd_idle_a:
    assert property ($past(ce_i) && !$past(rd_en_i) |-> rd_data_o == 16'h0000) else $error("read data not idle");
  pol_read_a:
    assert property (rd_en_i && addr_i == `AMOS_ADDR_POL |=> rd_data_o[15:5] == 11'h000 && !rd_data_o[3])
      else $error("polarity holds bad digits");
  dir_set_a:
    assert property (wr_en_i && ce_i && addr_i == `AMOS_ADDR_POL && wr_data_i == 16'h0010 |=> pulse_dir_rev_o)
      else $error("pulse direction not reversed");
  dir_hold_a:
    assert property ($changed(pulse_dir_rev_o) |-> $past(wr_en_i) &&
      $past(addr_i) inside {`AMOS_ADDR_POL, `AMOS_ADDR_PRST}) else $error("pulse direction moved alone");
  rst_code_a:
    assert property ($rose(rstn_i) |-> channel_one_proportion_code_o == 10'h200) else $error("code not mid scale at reset");
  prop_echo_a:
    assert property (wr_en_i && addr_i == `AMOS_ADDR_PROP1 && wr_data_i <= 16'h0064 ##2
      rd_en_i && addr_i == `AMOS_ADDR_PROP1 |=> rd_data_o == $past(wr_data_i, 3)) else $error("proportion lost");
  // main scenarios reached
  cover property (code_valid_o && channel_one_proportion_code_o == 10'h3FF);
  cover property (pulse_dir_rev_o);
  cover property (wr_en_i && addr_i == `AMOS_ADDR_PRST && wr_data_i == `AMOS_PRST_KEEP_DRIFT);
endmodule : amos_checker_props

bind amos_top amos_checker_props i_props (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .ce_i(ce_i),
  .addr_i(addr_i),
  .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i),
  .sample_valid_i(sample_valid_i),
  .rd_data_o(rd_data_o),
  .channel_one_proportion_code_o(channel_one_proportion_code_o),
  .code_valid_o(code_valid_o),
  .pulse_dir_rev_o(pulse_dir_rev_o)
);

// *** sim/amos_meter.sv ***
// bench-side meter reading a monitor converter code back as millivolts
`timescale 1ns/1ps
module amos_meter (
  input wire logic [9:0] code_i,
  output int mv_o
);
  // ideal 10-bit span of -8 V to +8 V; no smoothing, so a bad code shows at once
  always_comb mv_o = int'(code_i) * 16000 / 1023 - 8000;
endmodule : amos_meter

// *** sim/amos_top_test.sv ***
// self-checking bench of the analog monitor scaler
`timescale 1ns/1ps
`include "amos_consts.svh"
module amos_top_test;
  typedef struct {logic [15:0] src, pol; int p1, p2, d1, d2, s;} amos_row_t;
  // source, polarity, proportions, drifts, base sample
  amos_row_t rows [6] = '{
    '{16'h0010, 16'h0000, 100, 100, 0, 0, 16384},
    '{16'h0043, 16'h0001, 50, 100, 800, -800, 20000},
    '{16'h0025, 16'h0002, 100, 0, -800, 0, -32768},
    '{16'h0000, 16'h0000, 100, 100, -800, 800, -32768},
    '{16'h0011, 16'h0013, 100, 100, 800, 0, 32767},
    '{16'h0000, 16'h0000, 100, 100, 800, 800, 32767}};
  logic [15:0] ra [6] = '{`AMOS_ADDR_SRC, `AMOS_ADDR_POL, `AMOS_ADDR_PROP1, `AMOS_ADDR_PROP2,
    `AMOS_ADDR_DRIFT1, `AMOS_ADDR_DRIFT2};
  logic [15:0] rv [6] = '{16'h0001, 16'h0000, 16'h0064, 16'h0064, 16'h0000, 16'h0000};
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
  logic sample_valid_i = 1'b0, code_valid_o, pulse_dir_rev_o;
  logic [15:0] addr_i = 16'h0000, wr_data_i = 16'h0000, rd_data_o;
  logic signed [15:0] smp [6] = '{default: 16'sh0000};
  logic [9:0] channel_one_proportion_code_o, channel_two_proportion_code_o;
  int mv1, mv2, fails = 0, num_checks = 0, cyc = 0;

  amos_top i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .sample_valid_i(sample_valid_i),
    .speed_i(smp[0]), .torque_i(smp[1]), .pulse_freq_i(smp[2]), .speed_cmd_i(smp[3]),
    .torque_cmd_i(smp[4]), .bus_volt_i(smp[5]), .rd_data_o(rd_data_o), .channel_one_proportion_code_o(channel_one_proportion_code_o),
    .channel_two_proportion_code_o(channel_two_proportion_code_o), .code_valid_o(code_valid_o), .pulse_dir_rev_o(pulse_dir_rev_o));
  amos_meter i_m1 (.code_i(channel_one_proportion_code_o), .mv_o(mv1));
  amos_meter i_m2 (.code_i(channel_two_proportion_code_o), .mv_o(mv2));

  always #4 ref_clk_i = ~ref_clk_i;
  // hang guard; a full run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      test_done();
    end
  end

  // expected millivolts of one channel: sign, proportion, drift, then clamp
  function automatic int expc(int s, int k, bit neg, int p, int d);
    int v;
    v = s >>> k;
    if (neg) v = -v;
    v = ((v * p * 80) >>> 15) + d;
    if (v > 8000) v = 8000;
    if (v < -8000) v = -8000;
    return v;
  endfunction : expc

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string w);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", w, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string w);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1 chk(rd_data_o, e, w);
  endtask : rd

  // source k carries the base sample shifted right by k
  task automatic fire(input int s);
    @(posedge ref_clk_i);
    foreach (smp[k]) smp[k] <= 16'(s >>> k);
    sample_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b0;
    repeat (4) begin
      @(posedge ref_clk_i);
      #1;
      if (code_valid_o === 1'b1) break;
    end
  endtask : fire

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    int m1, m2;
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    foreach (rows[i]) begin
      wr(`AMOS_ADDR_SRC, rows[i].src);
      wr(`AMOS_ADDR_POL, rows[i].pol);
      wr(`AMOS_ADDR_PROP1, 16'(rows[i].p1));
      wr(`AMOS_ADDR_PROP2, 16'(rows[i].p2));
      wr(`AMOS_ADDR_DRIFT1, 16'(rows[i].d1));
      wr(`AMOS_ADDR_DRIFT2, 16'(rows[i].d2));
      fire(rows[i].s);
      m1 = expc(rows[i].s, rows[i].src[3:0], rows[i].pol[1], rows[i].p1, rows[i].d1);
      m2 = expc(rows[i].s, rows[i].src[7:4], rows[i].pol[0], rows[i].p2, rows[i].d2);
      chk(16'(channel_one_proportion_code_o), 16'((m1 + 8000) * 1023 / 16000), "ch1 code");
      chk(16'(channel_two_proportion_code_o), 16'((m2 + 8000) * 1023 / 16000), "ch2 code");
      chk(16'(pulse_dir_rev_o), 16'(rows[i].pol[4]), "direction");
      chk(16'(mv1 - m1 <= 20 && m1 - mv1 <= 20), 16'h0001, "meter ch1");
      chk(16'(mv2 - m2 <= 20 && m2 - mv2 <= 20), 16'h0001, "meter ch2");
      $display("row %0d done", i);
    end
    // refused values, then the reset command that must spare the drifts
    wr(`AMOS_ADDR_PROP1, 16'h0032);
    rd(`AMOS_ADDR_PROP1, 16'h0032, "prop1");
    wr(`AMOS_ADDR_PROP1, 16'h0065);
    wr(`AMOS_ADDR_DRIFT1, 16'h0321);
    wr(`AMOS_ADDR_DRIFT2, 16'hFCDF);
    rd(`AMOS_ADDR_PROP1, 16'h0032, "prop1 hold");
    wr(`AMOS_ADDR_POL, 16'h0010);
    #1 chk(16'(pulse_dir_rev_o), 16'h0001, "reverse");
    wr(`AMOS_ADDR_PRST, `AMOS_PRST_KEEP_DRIFT);
    rd(`AMOS_ADDR_PROP1, 16'h0064, "prop1 restored");
    rd(`AMOS_ADDR_DRIFT1, 16'h0320, "drift1 kept");
    rd(`AMOS_ADDR_DRIFT2, 16'h0320, "drift2 kept");
    rd(16'h0777, 16'h0000, "unmapped");
    chk(16'(pulse_dir_rev_o), 16'h0000, "forward");
    $display("keep test done");
    // a write while the clock enable is low must leave every setting frozen
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    wr(`AMOS_ADDR_POL, 16'h0010);
    ce_i <= 1'b1;
    #1 chk(16'(pulse_dir_rev_o), 16'h0000, "frozen direction");
    rd(`AMOS_ADDR_POL, 16'h0000, "frozen polarity");
    $display("enable test done");
    // second reset in mid-run, then the reset values of the source, polarity, proportion and drift registers
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    #1 chk(16'(channel_one_proportion_code_o), 16'h0200, "reset code");
    foreach (ra[i]) rd(ra[i], rv[i], "reset value");
    $display("reset test done");
    test_done();
  end
endmodule : amos_top_test
